// ===== common/irq_prio_defs.svh
// Purpose: constants for the processor interrupt priority logic
// Assumes: internal register numbers are word indexes on a private register port
// Notes: all offsets are dispatch offsets into the system control block
`ifndef IRQ_PRIO_DEFS_SVH
`define IRQ_PRIO_DEFS_SVH
`define REG_PRIORITY_LEVEL 6'h12
`define REG_SOFT_REQUEST 6'h14
`define REG_SOFT_SUMMARY 6'h15
`define IPL_HALT 5'h1f
`define IPL_POWER_FAIL 5'h1e
`define IPL_WRITE_ERR 5'h1d
`define IPL_READ_ERR 5'h1a
`define IPL_BUS_TAKEN 5'h17
`define IPL_INTERVAL 5'h16
`define IPL_DEVICE 5'h14
`define OFF_POWER_FAIL 16'h000c
`define OFF_WRITE_ERR 16'h0060
`define OFF_READ_ERR 16'h0054
`define OFF_INTERVAL 16'h00c0
`define OFF_CONSOLE_RX 16'h00f8
`define OFF_CONSOLE_TX 16'h00fc
`define OFF_TIMER0 16'h0078
`define OFF_TIMER1 16'h007c
`define OFF_STORAGE_EXT 16'h0108
`define OFF_STORAGE_INT 16'h0104
`define OFF_NETWORK 16'h010c
`define OFF_DOORBELL 16'h0204
`define OFF_BUS_BASE 16'h0200
`define OFF_SOFT_BASE 16'h0080
`define PSL_IPL_LSB 16
`define HALT_CODE_RESET 6'h03
`define HALT_CODE_EXTERNAL 6'h02
`endif

// ===== common/irq_prio_pkg.sv
// Purpose: types for the processor interrupt priority logic
// Assumes: defs header included alongside
// Notes: none
package irq_prio_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_DISPATCH = 2'b10
  } seq_state_t;
endpackage

// ===== hw/irq_source_pick.sv
// Purpose: picks the highest maskable request and its dispatch offset
// Assumes: request vector ordered within level by fixed precedence
// Notes: purely combinational
`timescale 1ns/1ps
`include "irq_prio_defs.svh"
module irq_source_pick (
  input wire logic [4:0] cur_ipl, // Current processor level
  input wire logic power_fail, // AC power-good lost
  input wire logic write_err, // Any write-side error
  input wire logic read_err, // Any correctable or I-stream error
  input wire logic [3:0] bus_req, // Bus requests, bit3 is level 7
  input wire logic [15:0] bus_vector, // Vector from requesting bus device
  input wire logic interval_tick, // Interval timer
  input wire logic [1:0] console_req, // Console receive, transmit
  input wire logic [1:0] timer_req, // Programmable timers 0, 1
  input wire logic storage_ext, // External storage port
  input wire logic storage_int, // Internal storage port
  input wire logic network_req, // Network port
  input wire logic doorbell_req, // Doorbell
  input wire logic [15:1] soft_pending, // Software summary
  output logic take, // A request beats current level
  output logic [4:0] take_ipl, // Level of the winner
  output logic [4:0] new_ipl, // Level to load on dispatch
  output logic [15:0] take_offset, // Dispatch offset
  output logic [3:0] take_bus, // One-hot bus line acknowledged
  output logic [15:1] take_soft // One-hot software level taken
);
  logic found;
  always_comb begin
    found = 1'b1;
    take_ipl = 5'h00;
    new_ipl = 5'h00;
    take_offset = 16'h0000;
    take_bus = 4'h0;
    take_soft = 15'h0000;
    // Fixed order inside a level decides ties
    if (power_fail) begin
      take_ipl = `IPL_POWER_FAIL;
      take_offset = `OFF_POWER_FAIL;
    end else if (write_err) begin
      take_ipl = `IPL_WRITE_ERR;
      take_offset = `OFF_WRITE_ERR;
    end else if (read_err) begin
      take_ipl = `IPL_READ_ERR;
      take_offset = `OFF_READ_ERR;
    end else if (bus_req[3]) begin
      take_ipl = 5'h17;
      take_bus = 4'h8;
    end else if (interval_tick) begin
      take_ipl = `IPL_INTERVAL;
      take_offset = `OFF_INTERVAL;
    end else if (bus_req[2]) begin
      take_ipl = 5'h16;
      take_bus = 4'h4;
    end else if (bus_req[1]) begin
      take_ipl = 5'h15;
      take_bus = 4'h2;
    end else if (console_req[0]) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_CONSOLE_RX;
    end else if (console_req[1]) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_CONSOLE_TX;
    end else if (timer_req[0]) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_TIMER0;
    end else if (timer_req[1]) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_TIMER1;
    end else if (storage_ext) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_STORAGE_EXT;
    end else if (storage_int) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_STORAGE_INT;
    end else if (network_req) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_NETWORK;
    end else if (doorbell_req) begin
      take_ipl = `IPL_DEVICE;
      take_offset = `OFF_DOORBELL;
    end else if (bus_req[0]) begin
      take_ipl = 5'h14;
      take_bus = 4'h1;
    end else begin
      found = 1'b0;
      for (int i = 15; i >= 1; i--) begin
        if (!found && soft_pending[i]) begin
          found = 1'b1;
          take_ipl = 5'(i);
          take_offset = `OFF_SOFT_BASE + 16'(4 * i);
          take_soft[i] = 1'b1;
        end
      end
    end
    if (take_bus != 4'h0) begin
      take_offset = bus_vector + `OFF_BUS_BASE;
    end
    // Bus, storage and network cannot tell grant levels apart
    if (take_bus != 4'h0 || take_offset == `OFF_STORAGE_EXT
        || take_offset == `OFF_STORAGE_INT || take_offset == `OFF_NETWORK) begin
      new_ipl = `IPL_BUS_TAKEN;
    end else begin
      new_ipl = take_ipl;
    end
    take = found && (take_ipl > cur_ipl);
  end
endmodule

// ===== hw/irq_priority_logic.sv
// Purpose: interrupt priority sequencing and level, request, summary registers
// Assumes: core holds off ack until instruction boundary; inputs synchronous
// Notes: power and halt inputs are sampled levels, edges found here for power only
`timescale 1ns/1ps
`include "irq_prio_defs.svh"
module irq_priority_logic (
  input wire logic clk, // 125 MHz processor clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic reg_wr, // Internal register write strobe
  input wire logic reg_rd, // Internal register read strobe
  input wire logic [5:0] reg_num, // Internal register number
  input wire logic [31:0] reg_wdata, // Write data
  output logic [31:0] reg_rdata, // Read data
  input wire logic dc_power_good, // Backplane DC power good
  input wire logic ac_power_good, // Backplane AC power good
  input wire logic bus_halt_line, // Backplane halt asserted
  input wire logic console_break, // Console break pulse
  input wire logic halt_protect, // Executing inside halt-protected space
  input wire logic power_up_reset, // Pulse after hardware reset
  input wire logic write_err, // Any write-side error
  input wire logic read_err, // Any correctable or I-stream error
  input wire logic [3:0] bus_req, // Request lines, bit3 level 7
  input wire logic [15:0] bus_vector, // Vector of requesting device
  input wire logic interval_tick, // Interval timer request
  input wire logic [1:0] console_req, // Console requests
  input wire logic [1:0] timer_req, // Programmable timer requests
  input wire logic storage_ext, // External storage request
  input wire logic storage_int, // Internal storage request
  input wire logic network_req, // Network request
  input wire logic doorbell_req, // Doorbell request
  input wire logic [31:0] cur_pc, // Program counter to save
  input wire logic [31:0] processor_status_longword, // Status to save
  input wire logic memory_mapping_enable, // Mapping enable to save
  input wire logic core_ack, // Core accepts halt or dispatch
  output logic halt_req, // Halt pending to firmware
  output logic [5:0] halt_code, // Saved halt code
  output logic [31:0] saved_pc, // Saved program counter
  output logic [31:0] saved_psl, // Saved status longword
  output logic saved_memory_mapping_enable, // Saved mapping enable
  output logic dispatch_req, // Maskable dispatch pending
  output logic [15:0] dispatch_offset, // Offset into control block
  output logic [3:0] bus_ack, // Bus line acknowledged, one cycle
  output logic [4:0] processor_priority_level // Current level
);
  irq_prio_pkg::seq_state_t state, next_state;
  logic [4:0] next_ipl;
  logic [15:1] soft_pending, next_soft;
  logic [5:0] next_code;
  logic [31:0] next_pc, next_psl;
  logic next_memory_mapping_enable;
  logic [15:0] next_offset;
  logic [3:0] next_bus_ack;
  logic dc_prev, ac_prev, dc_was_low, ac_was_low, next_dc_low, next_ac_low;
  logic reset_halt, ext_halt, next_reset_halt, next_ext_halt, break_seen, next_break;
  logic take;
  logic [4:0] take_ipl, new_ipl;
  logic [15:0] take_offset;
  logic [3:0] take_bus;
  logic [15:1] take_soft;
  logic power_fail;

  assign power_fail = ac_prev && !ac_power_good;

  irq_source_pick u_pick (
    .cur_ipl(processor_priority_level),
    .power_fail(power_fail),
    .write_err(write_err),
    .read_err(read_err),
    .bus_req(bus_req),
    .bus_vector(bus_vector),
    .interval_tick(interval_tick),
    .console_req(console_req),
    .timer_req(timer_req),
    .storage_ext(storage_ext),
    .storage_int(storage_int),
    .network_req(network_req),
    .doorbell_req(doorbell_req),
    .soft_pending(soft_pending),
    .take(take),
    .take_ipl(take_ipl),
    .new_ipl(new_ipl),
    .take_offset(take_offset),
    .take_bus(take_bus),
    .take_soft(take_soft)
  );

  // Power and halt event capture; set wins over the halt clearing them
  always_comb begin
    next_dc_low = dc_was_low;
    next_ac_low = ac_was_low;
    next_reset_halt = reset_halt;
    next_ext_halt = ext_halt;
    next_break = break_seen;
    if (state == irq_prio_pkg::ST_HALT && core_ack) begin
      next_reset_halt = 1'b0;
      next_ext_halt = 1'b0;
      next_break = 1'b0;
    end
    if (!dc_power_good) begin
      next_dc_low = 1'b1;
      if (!ac_power_good) begin
        next_ac_low = 1'b1;
      end
    end
    if (dc_power_good && !dc_prev && dc_was_low) begin
      next_dc_low = 1'b0;
      next_ac_low = 1'b0;
      if (ac_was_low) begin
        next_reset_halt = 1'b1;
      end else begin
        next_ext_halt = 1'b1;
      end
    end
    if (power_up_reset) begin
      next_reset_halt = 1'b1;
    end
    if (bus_halt_line || console_break) begin
      next_break = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dc_prev <= 1'b1;
      ac_prev <= 1'b1;
      dc_was_low <= 1'b0;
      ac_was_low <= 1'b0;
      reset_halt <= 1'b0;
      ext_halt <= 1'b0;
      break_seen <= 1'b0;
    end else begin
      dc_prev <= dc_power_good;
      ac_prev <= ac_power_good;
      dc_was_low <= next_dc_low;
      ac_was_low <= next_ac_low;
      reset_halt <= next_reset_halt;
      ext_halt <= next_ext_halt;
      break_seen <= next_break;
    end
  end

  // Sequencer, level and software summary
  always_comb begin
    next_state = state;
    next_ipl = processor_priority_level;
    next_soft = soft_pending;
    next_code = halt_code;
    next_pc = saved_pc;
    next_psl = saved_psl;
    next_memory_mapping_enable = saved_memory_mapping_enable;
    next_offset = dispatch_offset;
    next_bus_ack = 4'h0;
    if (reg_wr && reg_num == `REG_PRIORITY_LEVEL) begin
      next_ipl = reg_wdata[4:0];
    end
    if (reg_wr && reg_num == `REG_SOFT_SUMMARY) begin
      next_soft = reg_wdata[15:1];
    end
    case (state)
      irq_prio_pkg::ST_RUN: begin
        // Halt code 3 ignores protection; others only inside it, never masked
        if (reset_halt || ((ext_halt || break_seen) && halt_protect)) begin
          next_state = irq_prio_pkg::ST_HALT;
          next_code = reset_halt ? `HALT_CODE_RESET : `HALT_CODE_EXTERNAL;
          next_pc = cur_pc;
          next_psl = processor_status_longword;
          next_memory_mapping_enable = memory_mapping_enable;
          next_ipl = `IPL_HALT;
        end else if (take) begin
          next_state = irq_prio_pkg::ST_DISPATCH;
          next_pc = cur_pc;
          next_psl = processor_status_longword;
          next_offset = take_offset;
          next_ipl = new_ipl;
          next_bus_ack = take_bus;
          next_soft = next_soft & ~take_soft;
        end
      end
      irq_prio_pkg::ST_HALT: begin
        if (core_ack) begin
          next_state = irq_prio_pkg::ST_RUN;
        end
      end
      irq_prio_pkg::ST_DISPATCH: begin
        if (core_ack) begin
          next_state = irq_prio_pkg::ST_RUN;
        end
      end
      default: next_state = irq_prio_pkg::ST_RUN;
    endcase
    // Software request set wins over any clear this cycle
    if (reg_wr && reg_num == `REG_SOFT_REQUEST && reg_wdata[3:0] != 4'h0) begin
      next_soft[reg_wdata[3:0]] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= irq_prio_pkg::ST_RUN;
      processor_priority_level <= `IPL_HALT;
      soft_pending <= 15'h0000;
      halt_code <= 6'h00;
      saved_pc <= 32'h00000000;
      saved_psl <= 32'h00000000;
      saved_memory_mapping_enable <= 1'b0;
      dispatch_offset <= 16'h0000;
      bus_ack <= 4'h0;
    end else begin
      state <= next_state;
      processor_priority_level <= next_ipl;
      soft_pending <= next_soft;
      halt_code <= next_code;
      saved_pc <= next_pc;
      saved_psl <= next_psl;
      saved_memory_mapping_enable <= next_memory_mapping_enable;
      dispatch_offset <= next_offset;
      bus_ack <= next_bus_ack;
    end
  end

  assign halt_req = (state == irq_prio_pkg::ST_HALT);
  assign dispatch_req = (state == irq_prio_pkg::ST_DISPATCH);

  // Request register is write only and reads zero
  always_comb begin
    reg_rdata = 32'h00000000;
    if (reg_rd && reg_num == `REG_PRIORITY_LEVEL) begin
      reg_rdata = {27'h0000000, processor_priority_level};
    end else if (reg_rd && reg_num == `REG_SOFT_SUMMARY) begin
      reg_rdata = {16'h0000, soft_pending, 1'b0};
    end
  end

  property p_halt_level;
    @(posedge clk) disable iff (rst)
      $rose(halt_req) |-> processor_priority_level == 5'h1f;
  endproperty
  a_halt_level: assert property (p_halt_level) else $error("halt level not 1F");

  property p_reset_halt_code;
    @(posedge clk) disable iff (rst)
      (state == irq_prio_pkg::ST_RUN && reset_halt) |=> (halt_req && halt_code == 6'h03);
  endproperty
  a_reset_halt_code: assert property (p_reset_halt_code) else $error("code 3 halt missed");

  property p_protect;
    @(posedge clk) disable iff (rst)
      (state == irq_prio_pkg::ST_RUN && !reset_halt && !halt_protect && !take) |=> !halt_req;
  endproperty
  a_protect: assert property (p_protect) else $error("halt outside protected space");

  property p_save_pc;
    @(posedge clk) disable iff (rst)
      $rose(halt_req) |-> saved_pc == $past(cur_pc) && saved_memory_mapping_enable == $past(memory_mapping_enable);
  endproperty
  a_save_pc: assert property (p_save_pc) else $error("halt state not saved");

  property p_bus_level;
    @(posedge clk) disable iff (rst)
      (bus_ack != 4'h0) |-> processor_priority_level == 5'h17 && dispatch_req;
  endproperty
  a_bus_level: assert property (p_bus_level) else $error("bus level not 17");

  property p_bus_offset;
    @(posedge clk) disable iff (rst)
      (bus_ack != 4'h0) |-> dispatch_offset == $past(bus_vector) + 16'h0200;
  endproperty
  a_bus_offset: assert property (p_bus_offset) else $error("bus offset wrong");

  property p_dispatch_above;
    @(posedge clk) disable iff (rst)
      $rose(dispatch_req) |-> $past(take_ipl) > $past(processor_priority_level);
  endproperty
  a_dispatch_above: assert property (p_dispatch_above) else $error("dispatch not above level");

  property p_priority_level_reg_write;
    @(posedge clk) disable iff (rst)
      (reg_wr && reg_num == 6'h12 && state == irq_prio_pkg::ST_RUN && !take && !reset_halt
       && !((ext_halt || break_seen) && halt_protect))
      |=> processor_priority_level == $past(reg_wdata[4:0]);
  endproperty
  a_priority_level_reg_write: assert property (p_priority_level_reg_write) else $error("level write lost");

  property p_soft_set;
    @(posedge clk) disable iff (rst)
      (reg_wr && reg_num == 6'h14 && reg_wdata[3:0] == 4'h5) |=> soft_pending[5];
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("soft request lost");
endmodule

// ===== testbench/core_model.sv
// Purpose: processor core partner that accepts pending halts and dispatches
// Assumes: bench inputs change at the falling clock edge
// Notes: acceptance delay is chosen by the bench, 0 to 3 cycles
`timescale 1ns/1ps
module core_model (
  input wire logic clk, // Clock
  input wire logic halt_req, // Halt pending
  input wire logic dispatch_req, // Dispatch pending
  input wire logic [1:0] delay, // Cycles before accepting
  output logic core_ack // Accept pulse
);
  logic [1:0] waited;
  initial begin
    core_ack = 1'h0;
    waited = 2'h0;
  end
  // Ack is one cycle only, so a pending request is never accepted twice
  always @(negedge clk) begin
    if ((halt_req | dispatch_req) && !core_ack) begin
      core_ack <= (waited >= delay);
      waited <= waited + 2'h1;
    end else begin
      core_ack <= 1'h0;
      waited <= 2'h0;
    end
  end
endmodule

// ===== testbench/tb_cpu_interrupt_priority_logic.sv
// Purpose: self-checking bench for the interrupt priority logic
// Assumes: inputs change at the falling clock edge
// Notes: sources 0..14 follow the drive task order; random picks use a fixed seed
`timescale 1ns/1ps
`include "irq_prio_defs.svh"
module tb_cpu_interrupt_priority_logic;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [5:0] reg_num = 6'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic dc_power_good = 1'h1;
  logic ac_power_good = 1'h1;
  logic bus_halt_line = 1'h0;
  logic console_break = 1'h0;
  logic halt_protect = 1'h0;
  logic power_up_reset = 1'h0;
  logic write_err = 1'h0;
  logic read_err = 1'h0;
  logic [3:0] bus_req = 4'h0;
  logic [15:0] bus_vector = 16'h0;
  logic interval_tick = 1'h0;
  logic [1:0] console_req = 2'h0;
  logic [1:0] timer_req = 2'h0;
  logic storage_ext = 1'h0;
  logic storage_int = 1'h0;
  logic network_req = 1'h0;
  logic doorbell_req = 1'h0;
  logic [31:0] cur_pc = 32'h0;
  logic [31:0] processor_status_longword = 32'h0;
  logic memory_mapping_enable = 1'h1;
  logic [1:0] ack_delay = 2'h0;
  logic core_ack, halt_req, saved_memory_mapping_enable, dispatch_req;
  logic [5:0] halt_code;
  logic [31:0] saved_pc, saved_psl;
  logic [15:0] dispatch_offset;
  logic [3:0] bus_ack;
  logic [4:0] processor_priority_level;
  int miscompares = 0;
  int check_count = 0;
  int i;
  int l;

  always #4 clk = ~clk;

  irq_priority_logic u_dut (
    .clk, .rst, .reg_wr, .reg_rd, .reg_num, .reg_wdata, .reg_rdata, .dc_power_good,
    .ac_power_good, .bus_halt_line, .console_break, .halt_protect, .power_up_reset,
    .write_err, .read_err, .bus_req, .bus_vector, .interval_tick, .console_req, .timer_req,
    .storage_ext, .storage_int, .network_req, .doorbell_req, .cur_pc,
    .processor_status_longword, .memory_mapping_enable, .core_ack, .halt_req, .halt_code,
    .saved_pc, .saved_psl, .saved_memory_mapping_enable, .dispatch_req, .dispatch_offset, .bus_ack,
    .processor_priority_level
  );

  core_model u_core (.clk, .halt_req, .dispatch_req, .delay(ack_delay), .core_ack);

  task automatic summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] n, input logic [31:0] d);
    reg_num = n;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
    // Idle cycle so a following write never re-raises the strobe at once
    @(negedge clk);
  endtask

  task automatic rd(input logic [5:0] n, input logic [31:0] exp);
    reg_num = n;
    reg_rd = 1'h1;
    @(negedge clk);
    chk(reg_rdata, exp, "register read");
    reg_rd = 1'h0;
    @(negedge clk);
  endtask

  task automatic set_level(input logic [4:0] v);
    wr(`REG_PRIORITY_LEVEL, {27'h0, v});
  endtask

  task automatic drive(input int k, input logic v);
    case (k)
      0: write_err = v;
      1: read_err = v;
      2, 3, 4, 5: bus_req[k - 2] = v;
      6: interval_tick = v;
      7, 8: console_req[k - 7] = v;
      9, 10: timer_req[k - 9] = v;
      11: storage_ext = v;
      12: storage_int = v;
      13: network_req = v;
      default: doorbell_req = v;
    endcase
  endtask

  function automatic logic [4:0] src_lvl(input int k);
    if (k == 0) return 5'h1d;
    if (k == 1) return 5'h1a;
    if (k >= 2 && k <= 5) return 5'h12 + 5'(k);
    if (k == 6) return 5'h16;
    return 5'h14;
  endfunction

  // Bus lines and storage or network ports all land at 17
  function automatic logic [4:0] new_lvl(input int k);
    return ((k >= 2 && k <= 5) || (k >= 11 && k <= 13)) ? 5'h17 : src_lvl(k);
  endfunction

  function automatic logic [15:0] src_off(input int k);
    case (k)
      0: return 16'h0060;
      1: return 16'h0054;
      6: return 16'h00c0;
      7: return 16'h00f8;
      8: return 16'h00fc;
      9: return 16'h0078;
      10: return 16'h007c;
      11: return 16'h0108;
      12: return 16'h0104;
      13: return 16'h010c;
      14: return 16'h0204;
      default: return bus_vector + 16'h0200;
    endcase
  endfunction

  // Halts carry the code in val, dispatches the offset
  task automatic take(input logic halt, input logic [4:0] lvl, input logic [15:0] val);
    int n;
    n = 0;
    while ((halt ? halt_req : dispatch_req) !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n < 20, 1, "no request");
    chk(processor_priority_level, lvl, "level");
    chk(halt ? 16'(halt_code) : dispatch_offset, val, "code or offset");
    chk(saved_pc, cur_pc, "saved pc");
    chk(saved_psl, processor_status_longword, "saved status");
    if (halt) chk(saved_memory_mapping_enable, memory_mapping_enable, "saved mapping enable");
  endtask

  task automatic settle;
    int n;
    n = 0;
    while ((halt_req | dispatch_req) !== 1'h0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n < 20, 1, "request stuck");
    @(negedge clk);
  endtask

  task automatic quiet(input int k);
    repeat (k) begin
      @(negedge clk);
      chk({halt_req, dispatch_req}, 0, "unexpected take");
    end
  endtask

  initial begin
    #160000;
    miscompares++;
    $display("Error %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    void'($urandom(63));
    cur_pc = $urandom;
    processor_status_longword = $urandom;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    rd(`REG_PRIORITY_LEVEL, 32'h1f);
    rd(6'h13, 32'h0);
    power_up_reset = 1'h1;
    @(negedge clk);
    power_up_reset = 1'h0;
    take(1'h1, 5'h1f, 16'h3);
    settle();
    $display("test reset halt done");
    // Level 1F on early passes shows the level does not mask a halt
    for (i = 0; i < 3; i++) begin
      // Last pass starts at level 0 so the raise to 1F is visible
      if (i == 2) set_level(5'h0);
      cur_pc = $urandom;
      memory_mapping_enable = i[0];
      if (i == 0) bus_halt_line = 1'h1;
      if (i == 1) console_break = 1'h1;
      if (i == 2) dc_power_good = 1'h0;
      @(negedge clk);
      console_break = 1'h0;
      dc_power_good = 1'h1;
      quiet(5);
      halt_protect = 1'h1;
      take(1'h1, 5'h1f, 16'h2);
      bus_halt_line = 1'h0;
      settle();
      halt_protect = 1'h0;
    end
    $display("test external halts done");
    dc_power_good = 1'h0;
    ac_power_good = 1'h0;
    repeat (2) @(negedge clk);
    dc_power_good = 1'h1;
    take(1'h1, 5'h1f, 16'h3);
    ac_power_good = 1'h1;
    settle();
    set_level(5'h0);
    ac_power_good = 1'h0;
    take(1'h0, 5'h1e, 16'h000c);
    ac_power_good = 1'h1;
    settle();
    ac_power_good = 1'h0;
    quiet(4);
    ac_power_good = 1'h1;
    $display("test power events done");
    for (i = 0; i < 15; i++) begin
      bus_vector = 16'($urandom) & 16'hfffc;
      set_level(src_lvl(i));
      drive(i, 1'h1);
      quiet(3);
      set_level(src_lvl(i) - 5'h1);
      take(1'h0, new_lvl(i), src_off(i));
      chk(bus_ack, (i >= 2 && i <= 5) ? 4'h1 << (i - 2) : 4'h0, "bus ack");
      drive(i, 1'h0);
      settle();
    end
    set_level(5'h0);
    console_req = 2'h3;
    doorbell_req = 1'h1;
    take(1'h0, 5'h14, 16'h00f8);
    console_req = 2'h0;
    doorbell_req = 1'h0;
    settle();
    $display("test source table done");
    for (l = 15; l > 0; l--) begin
      set_level(5'h1f);
      wr(`REG_SOFT_REQUEST, 32'(l));
      rd(`REG_SOFT_SUMMARY, 32'h1 << l);
      set_level(5'(l - 1));
      take(1'h0, 5'(l), 16'h0080 + 16'(4 * l));
      settle();
      rd(`REG_SOFT_SUMMARY, 32'h0);
    end
    wr(`REG_SOFT_REQUEST, 32'h0);
    rd(`REG_SOFT_SUMMARY, 32'h0);
    set_level(5'h1f);
    wr(`REG_SOFT_SUMMARY, 32'h0000aaaa);
    rd(`REG_SOFT_SUMMARY, 32'h0000aaaa);
    wr(`REG_SOFT_SUMMARY, 32'h0);
    rd(`REG_SOFT_SUMMARY, 32'h0);
    $display("test software levels done");
    for (int n = 0; n < 30; n++) begin
      i = $urandom % 15;
      l = $urandom % 32;
      cur_pc = $urandom;
      processor_status_longword = $urandom;
      ack_delay = 2'($urandom);
      bus_vector = 16'($urandom) & 16'hfffc;
      set_level(5'(l));
      rd(`REG_PRIORITY_LEVEL, 32'(l));
      drive(i, 1'h1);
      if (src_lvl(i) > 5'(l)) take(1'h0, new_lvl(i), src_off(i));
      else quiet(3);
      drive(i, 1'h0);
      settle();
    end
    $display("test random sources done");
    summarize();
  end
endmodule
